// ===== src/fps_pkg.sv
// constants, tables and carrier types for the first fan-drive pwm channel
// assumes a 100 MHz core clock and a serial-interface front end elsewhere
package fps_pkg;

	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam logic [7:0] FPS_ADDR_SPINUP   = 8'hca;
	localparam logic [7:0] FPS_ADDR_FREQ     = 8'hcb;
	localparam logic [7:0] FPS_SPINUP_RESET  = 8'h00;
	localparam logic [7:0] FPS_FREQ_RESET    = 8'h00;
	localparam logic [7:0] FPS_FREQ_WMASK    = 8'h0f;
	localparam logic [7:0] FPS_READ_NONE     = 8'h00;
	localparam int         FPS_SPINUP_DUTY_CODE_LSB     = 0;
	localparam int         FPS_DUR_MSB_BIT   = 4;
	localparam int         FPS_DUR_LO_LSB    = 5;
	localparam int         FPS_FREQ_LSB      = 0;
	localparam int         FPS_MAP_BIT       = 3;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int FPS_CLK_HZ       = 100_000_000;
	localparam int FPS_TIME_BASE_MS = 1;
	localparam int FPS_TICK_CYCLES  = FPS_CLK_HZ / 1000 * FPS_TIME_BASE_MS;
	localparam int FPS_BP_FULL      = 10000;
	localparam int FPS_NUM_SRC      = 9;

	// ------------------------------------------------------------
	// carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] data;
	} fps_reg_req_t;

	typedef enum logic [2:0] {
		FPS_ST_OFF  = 3'b001,
		FPS_ST_SPIN = 3'b010,
		FPS_ST_RUN  = 3'b100
	} fps_state_t;

	// spin-up length in milliseconds, code 0 means none
	function automatic logic [14:0] fps_dur_ms(input logic [3:0] code);
		case (code)
			4'h1:    fps_dur_ms = 15'd100;
			4'h2:    fps_dur_ms = 15'd250;
			4'h3:    fps_dur_ms = 15'd400;
			4'h4:    fps_dur_ms = 15'd700;
			4'h5:    fps_dur_ms = 15'd1000;
			4'h6:    fps_dur_ms = 15'd2000;
			4'h7:    fps_dur_ms = 15'd4000;
			4'h0:    fps_dur_ms = 15'd0;
			default: fps_dur_ms = 15'(6000 + 2000 * (int'(code) - 8));
		endcase
	endfunction

	// output frequency in hz for each select code
	function automatic int fps_freq_hz(input logic [2:0] code);
		case (code)
			3'h0:    fps_freq_hz = 22500;
			3'h1:    fps_freq_hz = 96;
			3'h2:    fps_freq_hz = 84;
			3'h3:    fps_freq_hz = 72;
			3'h4:    fps_freq_hz = 60;
			3'h5:    fps_freq_hz = 48;
			3'h6:    fps_freq_hz = 36;
			default: fps_freq_hz = 12;
		endcase
	endfunction

	// duty in hundredths of a percent; codes above 13 stay at full
	function automatic logic [13:0] fps_duty_bp(input logic [3:0] code,
		input logic hf);
		logic [13:0] lo;
		lo = 14'd10000;
		case (code)
			4'h0: lo = 14'd0;
			4'h1: lo = 14'd2500;
			4'h2: lo = 14'd2857;
			4'h3: lo = 14'd3214;
			4'h4: lo = 14'd3571;
			4'h5: lo = 14'd3929;
			4'h6: lo = 14'd4286;
			4'h7: lo = 14'd4643;
			4'h8: lo = 14'd5000;
			4'h9: lo = 14'd5357;
			4'ha: lo = 14'd5714;
			4'hb: lo = 14'd7143;
			4'hc: lo = 14'd8571;
			default: lo = 14'd10000;
		endcase
		if (hf && code != 4'h0 && code < 4'hd)
			fps_duty_bp = 14'(2500 + 625 * (int'(code) - 1));
		else
			fps_duty_bp = lo;
	endfunction

endpackage

// ===== src/fps_pwm_one.sv
// spin-up, frequency select and duty map of the first fan-drive output
// requests arrive as 4-bit duty codes from the bound control sources
`timescale 1ns/1ps

// Function
// RQ1 - spin-up duty code in bits 3:0 maps like the lookup steps
// RQ2 - spin-up duty code zero means no spin-up at all
// RQ3 - duration code is bit 4 as msb, bits 7:5 as low bits
// RQ4 - zero to non-zero duty starts spin-up for the set duration
// RQ5 - duration codes map to 100 ms up to 20 s, zero disables
// RQ6 - frequency code in bits 2:0 picks 22500 Hz or 96 down to 12 Hz
// RQ7 - map select bit 3 acts only at 22.5 kHz, else low map
// RQ8 - chosen map applies to every source and to spin-up duty
// RQ9 - high map gives 25 percent plus 6.25 percent steps
// RQ10 - low map follows the thirteen listed percentages
// RQ11 - current duty readback is zero while spin-up is active
// RQ12 - largest duty requested by any bound source is driven
// RQ13 - frequency register bits 7:4 read zero, writes ignored
// RQ14 - spin-up timed by a millisecond tick counter, restarted each start
module fps_pwm_one
	import fps_pkg::*;
#(
	parameter int NUM_SRC     = FPS_NUM_SRC,
	parameter int TICK_CYCLES = FPS_TICK_CYCLES
)(
	input  wire logic                   clk_in,
	input  wire logic                   sys_rst_in,
	input  wire fps_reg_req_t           reg_req_in,
	input  wire logic [NUM_SRC-1:0][3:0] src_code_in,
	output logic      [7:0]             rd_data_out,
	output logic      [3:0]             current_duty_code_out,
	output logic                        spinup_active_out,
	output logic                        fan_drive_one_out
);

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	logic [7:0] spinup_cfg;
	logic [7:0] freq_cfg;
	logic [7:0] next_spinup_cfg;
	logic [7:0] next_freq_cfg;
	logic [7:0] next_rd_data;
	logic [3:0] spinup_duty_code;
	logic [3:0] spinup_duration_code;
	logic [2:0] output_frequency_select;
	logic       high_freq_map_select;
	logic       hf_active;

	assign spinup_duty_code = spinup_cfg[FPS_SPINUP_DUTY_CODE_LSB +: 4];
	// RQ3 split duration field
	assign spinup_duration_code = {spinup_cfg[FPS_DUR_MSB_BIT],
		spinup_cfg[FPS_DUR_LO_LSB +: 3]};
	assign output_frequency_select = freq_cfg[FPS_FREQ_LSB +: 3];
	assign high_freq_map_select = freq_cfg[FPS_MAP_BIT];
	// RQ7 map bit gated by frequency
	assign hf_active = high_freq_map_select
		&& (output_frequency_select == 3'h0);

	always_comb
	begin
		next_spinup_cfg = spinup_cfg;
		next_freq_cfg = freq_cfg;
		next_rd_data = rd_data_out;
		if (reg_req_in.wr && reg_req_in.addr == FPS_ADDR_SPINUP)
			next_spinup_cfg = reg_req_in.data;
		// RQ13 reserved bits dropped
		if (reg_req_in.wr && reg_req_in.addr == FPS_ADDR_FREQ)
			next_freq_cfg = reg_req_in.data & FPS_FREQ_WMASK;
		if (reg_req_in.rd)
		begin
			case (reg_req_in.addr)
				FPS_ADDR_SPINUP: next_rd_data = spinup_cfg;
				FPS_ADDR_FREQ:   next_rd_data = freq_cfg;
				default:         next_rd_data = FPS_READ_NONE;
			endcase
		end
	end

	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
		begin
			spinup_cfg <= FPS_SPINUP_RESET;
			freq_cfg <= FPS_FREQ_RESET;
			rd_data_out <= FPS_READ_NONE;
		end
		else
		begin
			spinup_cfg <= next_spinup_cfg;
			freq_cfg <= next_freq_cfg;
			rd_data_out <= next_rd_data;
		end
	end

	// ------------------------------------------------------------
	// source arbitration
	// ------------------------------------------------------------
	logic [3:0] max_chain [0:NUM_SRC];
	logic [3:0] req_max;

	assign max_chain[0] = 4'h0;
	genvar gi;
	generate
		for (gi = 0; gi < NUM_SRC; gi++)
		begin : g_max
			// RQ12 running maximum
			assign max_chain[gi+1] = (src_code_in[gi] > max_chain[gi])
				? src_code_in[gi] : max_chain[gi];
			// RQ12 never below a source
			max_dominates_a: assert property (@(posedge clk_in)
				disable iff (sys_rst_in)
				req_max >= src_code_in[gi])
				else $error("arbitrated duty below a source");
		end
	endgenerate
	assign req_max = max_chain[NUM_SRC];

	// ------------------------------------------------------------
	// spin-up sequencer
	// ------------------------------------------------------------
	fps_state_t  state;
	fps_state_t  next_state;
	logic [16:0] tick_cnt;
	logic [16:0] next_tick_cnt;
	logic [14:0] ms_cnt;
	logic [14:0] next_ms_cnt;
	logic [14:0] dur_ms;
	logic        tick;
	logic        spin_ok;
	logic [3:0]  applied_code;

	// RQ5 duration table
	assign dur_ms = fps_dur_ms(spinup_duration_code);
	// RQ14 fixed millisecond base
	assign tick = (tick_cnt == 17'(TICK_CYCLES - 1));
	// RQ2 zero duty or zero length skips spin-up
	assign spin_ok = (spinup_duty_code != 4'h0) && (dur_ms != 15'd0);

	always_comb
	begin
		next_state = state;
		next_tick_cnt = tick ? 17'd0 : tick_cnt + 17'd1;
		next_ms_cnt = ms_cnt;
		case (state)
			FPS_ST_OFF:
			begin
				// RQ4 start on zero to non-zero
				if (req_max != 4'h0)
				begin
					next_state = spin_ok ? FPS_ST_SPIN : FPS_ST_RUN;
					// RQ14 restart timer
					next_ms_cnt = 15'd0;
					next_tick_cnt = 17'd0;
				end
			end
			FPS_ST_SPIN:
			begin
				if (req_max == 4'h0)
					next_state = FPS_ST_OFF;
				else if (ms_cnt >= dur_ms)
					next_state = FPS_ST_RUN;
				else if (tick)
					next_ms_cnt = ms_cnt + 15'd1;
			end
			FPS_ST_RUN:
			begin
				if (req_max == 4'h0)
					next_state = FPS_ST_OFF;
			end
			default: next_state = FPS_ST_OFF;
		endcase
	end

	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
		begin
			state <= FPS_ST_OFF;
			tick_cnt <= 17'd0;
			ms_cnt <= 15'd0;
		end
		else
		begin
			state <= next_state;
			tick_cnt <= next_tick_cnt;
			ms_cnt <= next_ms_cnt;
		end
	end

	// RQ1 spin-up duty overrides
	assign applied_code = (state == FPS_ST_SPIN) ? spinup_duty_code
		: req_max;

	// ------------------------------------------------------------
	// pwm generator
	// ------------------------------------------------------------
	logic [23:0] period;
	logic [23:0] per_cnt;
	logic [23:0] next_per_cnt;
	logic [23:0] thresh;
	logic [23:0] next_thresh;
	logic [13:0] duty_bp;
	logic [39:0] prod;
	logic        next_drive;
	logic [3:0]  next_cur_code;

	// RQ6 period from frequency code
	assign period = 24'(FPS_CLK_HZ / fps_freq_hz(output_frequency_select));
	// RQ8 one map for every source
	// RQ9 RQ10 map tables
	assign duty_bp = fps_duty_bp(applied_code, hf_active);
	assign prod = 40'(period) * 40'(duty_bp);

	// threshold only moves at a period boundary, so no runt pulses
	always_comb
	begin
		next_per_cnt = per_cnt + 24'd1;
		next_thresh = thresh;
		if (per_cnt >= period - 24'd1)
		begin
			next_per_cnt = 24'd0;
			next_thresh = 24'(prod / 40'(FPS_BP_FULL));
		end
		next_drive = (next_per_cnt < next_thresh);
		// RQ11 readback blanked in spin-up
		next_cur_code = (state == FPS_ST_SPIN) ? 4'h0 : applied_code;
	end

	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
		begin
			per_cnt <= 24'd0;
			thresh <= 24'd0;
			fan_drive_one_out <= 1'b0;
			current_duty_code_out <= 4'h0;
			spinup_active_out <= 1'b0;
		end
		else
		begin
			per_cnt <= next_per_cnt;
			thresh <= next_thresh;
			fan_drive_one_out <= next_drive;
			current_duty_code_out <= next_cur_code;
			spinup_active_out <= (state == FPS_ST_SPIN);
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	sequence s_rise;
		state == FPS_ST_OFF && req_max != 4'h0;
	endsequence

	spin_entry_a: assert property (@(posedge clk_in) // RQ4
		disable iff (sys_rst_in)
		(s_rise and spin_ok) |=> state == FPS_ST_SPIN)
		else $error("spin-up not started on duty rise");
	spin_skip_a: assert property (@(posedge clk_in) // RQ2
		disable iff (sys_rst_in)
		(s_rise and !spin_ok) |=> state == FPS_ST_RUN)
		else $error("spin-up entered while disabled");
	spin_duty_a: assert property (@(posedge clk_in) // RQ1
		disable iff (sys_rst_in)
		state == FPS_ST_SPIN |-> duty_bp == fps_duty_bp(spinup_duty_code,
		hf_active))
		else $error("spin-up duty not applied");
	spin_length_a: assert property (@(posedge clk_in) // RQ5
		disable iff (sys_rst_in)
		state == FPS_ST_SPIN |-> ms_cnt <= dur_ms)
		else $error("spin-up ran past its duration");
	timer_restart_a: assert property (@(posedge clk_in) // RQ14
		disable iff (sys_rst_in) s_rise |=> ms_cnt == 15'd0)
		else $error("spin-up timer not restarted");
	read_blank_a: assert property (@(posedge clk_in) // RQ11
		disable iff (sys_rst_in)
		state == FPS_ST_SPIN |=> current_duty_code_out == 4'h0)
		else $error("duty readback not zero in spin-up");
	reserved_zero_a: assert property (@(posedge clk_in) // RQ13
		disable iff (sys_rst_in) freq_cfg[7:4] == 4'h0)
		else $error("reserved frequency bits set");
	low_map_a: assert property (@(posedge clk_in) // RQ7
		disable iff (sys_rst_in)
		output_frequency_select != 3'h0 |-> !hf_active)
		else $error("high map used off 22.5 kHz");
	full_on_a: assert property (@(posedge clk_in) // RQ9
		disable iff (sys_rst_in)
		applied_code == 4'hd |-> duty_bp == 14'd10000)
		else $error("step thirteen not full duty");

endmodule // fps_pwm_one

// ===== testbench/fps_fan_model.sv
// fan drive load model: measures period and high time of the drive
// assumes the drive is sampled on the rising core clock edge
`timescale 1ns/1ps
module fps_fan_model
(
	input  wire logic        clk_in,
	input  wire logic        drive_in,
	output logic      [15:0] period_out,
	output logic      [15:0] high_out,
	output logic             upd_out
);
	logic        prev = 1'b0;
	logic [15:0] cnt  = 16'h0000;
	logic [15:0] hcnt = 16'h0000;
	// a rising edge closes one period; steady 0 or 1 gives no update
	always_ff @(posedge clk_in)
	begin
		prev    <= drive_in;
		upd_out <= drive_in && !prev;
		if (drive_in && !prev)
		begin
			period_out <= cnt;
			high_out   <= hcnt;
			cnt        <= 16'h0001;
			hcnt       <= 16'h0001;
		end
		else
		begin
			cnt  <= cnt + 16'h0001;
			hcnt <= hcnt + 16'(drive_in);
		end
	end
endmodule // fps_fan_model

// ===== testbench/testbench.sv
// self-checking bench of the first fan-drive output
// assumes fps_pkg, fps_pwm_one and fps_fan_model are compiled first
`timescale 1ns/1ps
module testbench;
	import fps_pkg::*;
	// short tick keeps the long spin-up codes within the run
	localparam int TICK = 5;
	localparam int PER  = 100_000_000 / 22500;
	logic                        clk_in     = 1'b0;
	logic                        sys_rst_in = 1'b1;
	fps_reg_req_t                reg_req_in = '0;
	logic [FPS_NUM_SRC-1:0][3:0] src_code_in = '0;
	logic [7:0]                  rd_data_out;
	logic [3:0]                  current_duty_code_out;
	logic                        spinup_active_out;
	logic                        fan_drive_one_out;
	logic [15:0]                 period;
	logic [15:0]                 high;
	logic                        upd;
	logic [31:0]                 lfsr = 32'h9b9e688e;
	logic [7:0]                  d;
	logic [3:0]                  mx;
	int                          fail_count  = 0;
	int                          comparisons = 0;
	int                          cycles      = 0;
	int                          n;
	fps_pwm_one #(.TICK_CYCLES(TICK)) i_dut (.clk_in(clk_in),
		.sys_rst_in(sys_rst_in), .reg_req_in(reg_req_in),
		.src_code_in(src_code_in), .rd_data_out(rd_data_out),
		.current_duty_code_out(current_duty_code_out),
		.spinup_active_out(spinup_active_out),
		.fan_drive_one_out(fan_drive_one_out));
	fps_fan_model i_fan (.clk_in(clk_in), .drive_in(fan_drive_one_out),
		.period_out(period), .high_out(high), .upd_out(upd));
	// ----
	// helpers
	// ----
	initial
	begin
		forever #5 clk_in = ~clk_in;
	end
	always @(posedge clk_in)
	begin
		cycles++;
		// about 80k cycles needed; a hang stops here
		if (cycles == 100000)
		begin
			fail_count++;
			$display("[ERR] %0t timeout", $time);
			stop_test();
		end
	end
	function automatic logic [31:0] next_rand();
		lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
		return lfsr;
	endfunction
	function automatic int exp_bp(input logic [3:0] c, input logic hf);
		int lo[16] = '{0, 2500, 2857, 3214, 3571, 3929, 4286, 4643, 5000,
			5357, 5714, 7143, 8571, 10000, 10000, 10000};
		if (hf && c != 4'h0 && c < 4'hd)
			return 2500 + 625 * (int'(c) - 1);
		return lo[c];
	endfunction
	task automatic check(input logic [15:0] got, input logic [15:0] e,
		input string what);
		comparisons++;
		if (got !== e)
		begin
			fail_count++;
			$display("[ERR] %0t %s got %0h exp %0h", $time, what, got, e);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [7:0] v);
		@(negedge clk_in);
		reg_req_in = '{wr: w, rd: !w, addr: a, data: v};
		@(negedge clk_in);
		reg_req_in = '0;
		@(negedge clk_in);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		bus(1'b0, a, 8'h00);
		check(16'(rd_data_out), 16'(e), "read");
	endtask
	// third period after a change is clean of the reload boundary
	task automatic meas(input int e);
		int got;
		repeat (3)
		begin
			n = 0;
			while (upd !== 1'b1 && n < 20000)
			begin
				@(negedge clk_in);
				n++;
			end
			@(negedge clk_in);
		end
		got = int'(high) * 10000 / int'(period);
		check(period, 16'(PER), "period");
		check(16'(got >= e - 5 && got <= e + 5), 16'h0001, "duty");
	endtask
	task automatic spin(input logic [7:0] cfg, input int ms,
		input logic [3:0] code, input int e);
		realtime t0;
		bus(1'b1, FPS_ADDR_SPINUP, cfg);
		src_code_in = '0;
		repeat (3) @(negedge clk_in);
		src_code_in[2] = code;
		t0 = $realtime;
		repeat (3) @(negedge clk_in);
		check(16'(spinup_active_out), 16'h0001, "spin start");
		check(16'(current_duty_code_out), 16'h0000, "spin rdback");
		if (e > 0)
			meas(e);
		n = 0;
		while (spinup_active_out !== 1'b0 && n < 40000)
		begin
			@(negedge clk_in);
			n++;
		end
		n = int'(($realtime - t0) / 10.0);
		check(16'(n >= ms * TICK && n <= ms * TICK + TICK + 6), 16'h0001,
			"spin length");
		repeat (3) @(negedge clk_in);
		check(16'(current_duty_code_out), 16'(code), "after spin");
	endtask
	task automatic stop_test();
		$display("checks %0d errors %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// ----
	// main sequence
	// ----
	initial
	begin
		repeat (8) @(negedge clk_in);
		sys_rst_in = 1'b0;
		rd(FPS_ADDR_SPINUP, FPS_SPINUP_RESET);
		rd(FPS_ADDR_FREQ, FPS_FREQ_RESET);
		for (int i = 0; i < 8; i++)
		begin
			d = {8'(next_rand())} & 8'hf8 | 8'(i);
			bus(1'b1, FPS_ADDR_SPINUP, d);
			bus(1'b1, 8'h40 | 8'(i), ~d);
			rd(FPS_ADDR_SPINUP, d);
			bus(1'b1, FPS_ADDR_FREQ, d);
			rd(FPS_ADDR_FREQ, d & 8'h0f);
			rd(8'h40 | 8'(i), 8'h00);
		end
		// zero spin-up duty with a long duration: no spin-up at all
		bus(1'b1, FPS_ADDR_SPINUP, 8'he0);
		for (int r = 0; r < 8; r++)
		begin
			mx = 4'h0;
			for (int s = 0; s < FPS_NUM_SRC; s++)
			begin
				src_code_in[s] = (r == 0 && s == 0) ? 4'hf : 4'(next_rand());
				mx = (src_code_in[s] > mx) ? src_code_in[s] : mx;
			end
			repeat (4) @(negedge clk_in);
			check(16'(spinup_active_out), 16'h0000, "no spin");
			check(16'(current_duty_code_out), 16'(mx), "max");
		end
		bus(1'b1, FPS_ADDR_FREQ, 8'h08);
		src_code_in = '0;
		src_code_in[5] = 4'(next_rand() % 12 + 1);
		meas(exp_bp(src_code_in[5], 1'b1));
		bus(1'b1, FPS_ADDR_FREQ, 8'h00);
		src_code_in[5] = 4'hb;
		meas(exp_bp(4'hb, 1'b0));
		bus(1'b1, FPS_ADDR_FREQ, 8'h08);
		spin(8'he4, 4000, 4'h9, exp_bp(4'h4, 1'b1));
		spin(8'h19, 6000, 4'h3, 0);
		stop_test();
	end
endmodule // testbench
